// ===== logic/position_velocity_monitor.sv
/*
 position_velocity_monitor: sampled motion objects, lag error and
 arrival window supervision, object read/write port.
 Assumes motion values arrive synchronous to i_core_clk from the control
 loops and that the object port master keeps one access per request.
*/
`timescale 1ns/100ps
`default_nettype none

module position_velocity_monitor
    import pvm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire motion_in_t i_motion,
    input wire logic i_homing_done,
    input wire logic i_lag_reaction_en,
    input wire logic i_obj_req,
    input wire logic i_obj_wr,
    input wire logic [15:0] i_obj_index,
    input wire logic [31:0] i_obj_wdata,
    output logic o_obj_ack,
    output logic o_obj_err,
    output logic [31:0] o_obj_rdata,
    output logic o_raw_valid,
    output logic [15:0] o_status_bits,
    output monitor_out_t o_mon
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_FLAG = 3'b100
    } timer_state_t;

    logic signed [7:0] mode_q;
    logic signed [31:0] demand_q, target_q, raw_q, actual_q;
    logic signed [31:0] sset_q, sact_q;
    logic [31:0] enc_res_q;
    logic [31:0] lag_limit_q, arr_window_q;
    logic [15:0] lag_timeout_q, arr_time_q;
    logic [15:0] tick_cnt_q;
    logic tick_q;
    logic [16:0] lag_ms_q, arr_ms_q;
    timer_state_t lag_st_q, arr_st_q;
    logic [32:0] lag_diff, arr_diff;
    logic [31:0] lag_abs, arr_abs;
    logic lag_cond, arr_cond, pos_mode;

    // capture motion snapshot every cycle
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q <= RST_MODE_SHOWN;
            demand_q <= RST_POS;
            target_q <= RST_POS;
            raw_q <= RST_POS;
            actual_q <= RST_POS;
            sset_q <= RST_POS;
            sact_q <= RST_POS;
            enc_res_q <= RST_POS;
        end else begin
            mode_q <= i_motion.mode;
            demand_q <= i_homing_done ? RST_POS : i_motion.demand_pos;
            // homing never touches the encoder count
            raw_q <= i_motion.raw_enc_pos;
            actual_q <= i_homing_done ? RST_POS : i_motion.actual_pos;
            target_q <= i_motion.target_pos;
            sset_q <= i_motion.speed_setpt;
            sact_q <= i_motion.speed_actual;
            enc_res_q <= i_motion.enc_resolution;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_raw_valid <= 1'b0;
        end else begin
            o_raw_valid <= (enc_res_q != 32'h00000000);
        end
    end

    // settings written over the object port
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            lag_limit_q <= RST_LAG_LIMIT;
            lag_timeout_q <= RST_LAG_TIMEOUT;
            arr_window_q <= RST_ARR_WINDOW;
            arr_time_q <= RST_ARR_TIME;
        end else if (i_obj_req && i_obj_wr) begin
            case (i_obj_index)
                IDX_LAG_LIMIT: lag_limit_q <= i_obj_wdata;
                IDX_LAG_TIMEOUT: lag_timeout_q <= i_obj_wdata[15:0];
                IDX_ARR_WINDOW: arr_window_q <= i_obj_wdata;
                IDX_ARR_TIME: arr_time_q <= i_obj_wdata[15:0];
                default: ;
            endcase
        end
    end

    // object reads; writes to read-only or unknown objects are refused
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_obj_ack <= 1'b0;
            o_obj_err <= 1'b0;
            o_obj_rdata <= 32'h00000000;
        end else begin
            o_obj_ack <= i_obj_req;
            o_obj_err <= 1'b0;
            o_obj_rdata <= 32'h00000000;
            if (i_obj_req) begin
                case (i_obj_index)
                    IDX_MODE_SHOWN: begin
                        o_obj_rdata <= {{24{mode_q[7]}}, mode_q};
                        o_obj_err <= i_obj_wr;
                    end
                    IDX_DEMAND_POS: begin
                        o_obj_rdata <= demand_q;
                        o_obj_err <= i_obj_wr;
                    end
                    IDX_RAW_ENC_POS: begin
                        o_obj_rdata <= raw_q;
                        o_obj_err <= i_obj_wr;
                    end
                    IDX_ACTUAL_POS: begin
                        o_obj_rdata <= actual_q;
                        o_obj_err <= i_obj_wr;
                    end
                    IDX_SPEED_SETPT: begin
                        o_obj_rdata <= sset_q;
                        o_obj_err <= i_obj_wr;
                    end
                    IDX_SPEED_ACTUAL: begin
                        o_obj_rdata <= sact_q;
                        o_obj_err <= i_obj_wr;
                    end
                    IDX_LAG_LIMIT: o_obj_rdata <= lag_limit_q;
                    IDX_LAG_TIMEOUT: o_obj_rdata <= {16'h0000, lag_timeout_q};
                    IDX_ARR_WINDOW: o_obj_rdata <= arr_window_q;
                    IDX_ARR_TIME: o_obj_rdata <= {16'h0000, arr_time_q};
                    default: o_obj_err <= 1'b1;
                endcase
            end
        end
    end

    // millisecond tick from the core clock
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_LAST);
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 16'h0000
                                                    : tick_cnt_q + 16'h0001;
        end
    end

    // 33-bit differences avoid overflow at the range ends
    always_comb begin
        lag_diff = {actual_q[31], actual_q} - {demand_q[31], demand_q};
        arr_diff = {actual_q[31], actual_q} - {target_q[31], target_q};
        lag_abs = lag_diff[32] ? 32'(-lag_diff) : lag_diff[31:0];
        arr_abs = arr_diff[32] ? 32'(-arr_diff) : arr_diff[31:0];
        pos_mode = (mode_q == MODE_PROFILE_POS) ||
                   (mode_q == MODE_INTERP_POS);
        lag_cond = (lag_limit_q != MON_OFF) && (lag_abs > lag_limit_q);
        arr_cond = (arr_window_q != MON_OFF) && pos_mode &&
                   (arr_abs < arr_window_q);
    end

    // lag persistence: flag once count passes the timeout
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            lag_st_q <= ST_IDLE;
            lag_ms_q <= 17'h00000;
        end else begin
            case (lag_st_q)
                ST_IDLE: begin
                    lag_ms_q <= 17'h00000;
                    if (lag_cond) lag_st_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (!lag_cond) begin
                        lag_st_q <= ST_IDLE;
                    end else if (lag_ms_q > {1'b0, lag_timeout_q}) begin
                        lag_st_q <= ST_FLAG;
                    end else if (tick_q) begin
                        lag_ms_q <= lag_ms_q + 17'h00001;
                    end
                end
                ST_FLAG: if (!lag_cond) lag_st_q <= ST_IDLE;
                default: lag_st_q <= ST_IDLE;
            endcase
        end
    end

    // arrival persistence uses the window time setting
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            arr_st_q <= ST_IDLE;
            arr_ms_q <= 17'h00000;
        end else begin
            case (arr_st_q)
                ST_IDLE: begin
                    arr_ms_q <= 17'h00000;
                    if (arr_cond) arr_st_q <= ST_RUN;
                end
                ST_RUN: begin
                    if (!arr_cond) begin
                        arr_st_q <= ST_IDLE;
                    end else if (arr_ms_q > {1'b0, arr_time_q}) begin
                        arr_st_q <= ST_FLAG;
                    end else if (tick_q) begin
                        arr_ms_q <= arr_ms_q + 17'h00001;
                    end
                end
                ST_FLAG: if (!arr_cond) arr_st_q <= ST_IDLE;
                default: arr_st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_status_bits <= 16'h0000;
            o_mon <= '0;
        end else begin
            o_status_bits <= 16'h0000;
            o_status_bits[STAT_LAG_BIT] <= (lag_st_q == ST_FLAG);
            o_status_bits[STAT_TARGET_BIT] <= (arr_st_q == ST_FLAG);
            o_mon.lag_error <= (lag_st_q == ST_FLAG);
            o_mon.target_reached <= (arr_st_q == ST_FLAG);
            o_mon.lag_event <= (lag_st_q == ST_RUN) &&
                               (lag_ms_q > {1'b0, lag_timeout_q}) && lag_cond;
            // history only when a reaction is armed
            o_mon.history_entry <= (lag_st_q == ST_RUN) && lag_cond &&
                                   (lag_ms_q > {1'b0, lag_timeout_q}) &&
                                   i_lag_reaction_en;
        end
    end

    lag_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        lag_st_q == ST_FLAG |=> o_status_bits[13])
        else $error("lag flag missing");
    lag_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        lag_limit_q == MON_OFF |-> !lag_cond)
        else $error("lag monitor not disabled");
    lag_persist_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(lag_st_q == ST_FLAG) |-> lag_ms_q > {1'b0, lag_timeout_q})
        else $error("lag flagged early");
    arr_persist_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(arr_st_q == ST_FLAG) |-> arr_ms_q > {1'b0, arr_time_q})
        else $error("arrival flagged early");
    arr_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        arr_window_q == MON_OFF |=> ##1 !o_status_bits[10])
        else $error("arrival monitor not disabled");
    timer_restart_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        lag_st_q == ST_RUN && !lag_cond |=> lag_st_q == ST_IDLE)
        else $error("lag timer not restarted");
    raw_valid_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        enc_res_q == 32'h00000000 |=> !o_raw_valid)
        else $error("raw valid with zero resolution");
    history_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_mon.history_entry ==
        (o_mon.lag_event && $past(i_lag_reaction_en)))
        else $error("history entry does not follow armed lag event");
    raw_homing_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_homing_done |=> raw_q == $past(i_motion.raw_enc_pos))
        else $error("raw position cleared by homing");
    obj_ack_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_obj_req |=> o_obj_ack)
        else $error("object access not answered");

    lag_flag_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_status_bits[13]));
    arr_flag_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_status_bits[10]));
    hist_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
        o_mon.history_entry);
    wr_c: cover property (@(posedge i_core_clk) disable iff (i_rst)
        i_obj_req && i_obj_wr && i_obj_index == IDX_LAG_LIMIT);

endmodule

`default_nettype wire

// ===== logic/pvm_pkg.sv
/*
 pvm_pkg: object indices, reset values, mode codes, status bit positions
 and carrier structs for the position and velocity monitor.
 Assumes a 50 MHz core clock and an object access port indexed by the
 16-bit object index.
*/
`default_nettype none

package pvm_pkg;

    localparam logic [15:0] IDX_MODE_SHOWN = 16'h6061;
    localparam logic [15:0] IDX_DEMAND_POS = 16'h6062;
    localparam logic [15:0] IDX_RAW_ENC_POS = 16'h6063;
    localparam logic [15:0] IDX_ACTUAL_POS = 16'h6064;
    localparam logic [15:0] IDX_LAG_LIMIT = 16'h6065;
    localparam logic [15:0] IDX_LAG_TIMEOUT = 16'h6066;
    localparam logic [15:0] IDX_ARR_WINDOW = 16'h6067;
    localparam logic [15:0] IDX_ARR_TIME = 16'h6068;
    localparam logic [15:0] IDX_SPEED_SETPT = 16'h606B;
    localparam logic [15:0] IDX_SPEED_ACTUAL = 16'h606C;

    localparam logic [7:0] RST_MODE_SHOWN = 8'h00;
    localparam logic [31:0] RST_POS = 32'h00000000;
    localparam logic [31:0] RST_LAG_LIMIT = 32'h00000100;
    localparam logic [15:0] RST_LAG_TIMEOUT = 16'h0064;
    localparam logic [31:0] RST_ARR_WINDOW = 32'h0000000A;
    localparam logic [15:0] RST_ARR_TIME = 16'h0064;
    localparam logic [31:0] MON_OFF = 32'hFFFFFFFF;

    localparam int STAT_TARGET_BIT = 10;
    localparam int STAT_LAG_BIT = 13;

    localparam int TICK_PERIOD_US = 1000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_CYCLES = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    localparam logic signed [7:0] MODE_AUTO_SETUP = 8'shFE;
    localparam logic signed [7:0] MODE_CLOCK_DIR = 8'shFF;
    localparam logic signed [7:0] MODE_NONE = 8'sh00;
    localparam logic signed [7:0] MODE_PROFILE_POS = 8'sh01;
    localparam logic signed [7:0] MODE_VELOCITY = 8'sh02;
    localparam logic signed [7:0] MODE_PROFILE_VEL = 8'sh03;
    localparam logic signed [7:0] MODE_PROFILE_TRQ = 8'sh04;
    localparam logic signed [7:0] MODE_HOMING = 8'sh06;
    localparam logic signed [7:0] MODE_INTERP_POS = 8'sh07;
    localparam logic signed [7:0] MODE_CSP = 8'sh08;
    localparam logic signed [7:0] MODE_CSV = 8'sh09;
    localparam logic signed [7:0] MODE_CST = 8'sh0A;

    typedef struct packed {
        logic signed [7:0] mode;
        logic signed [31:0] demand_pos;
        logic signed [31:0] target_pos;
        logic signed [31:0] raw_enc_pos;
        logic signed [31:0] actual_pos;
        logic signed [31:0] speed_setpt;
        logic signed [31:0] speed_actual;
        logic [31:0] enc_resolution;
    } motion_in_t;

    typedef struct packed {
        logic lag_error;
        logic target_reached;
        logic lag_event;
        logic history_entry;
    } monitor_out_t;

endpackage

`default_nettype wire

// ===== bench/object_master.sv
/*
 object_master: stand-in for the fieldbus master on the object port.
 Assumes the port takes one access per cycle of i_obj_req and answers
 with a one-cycle ack on the following cycle.
*/
`timescale 1ns/100ps
`default_nettype none

module object_master (
    input wire logic i_core_clk,
    input wire logic i_obj_ack,
    input wire logic i_obj_err,
    input wire logic [31:0] i_obj_rdata,
    output logic o_obj_req,
    output logic o_obj_wr,
    output logic [15:0] o_obj_index,
    output logic [31:0] o_obj_wdata
);
    initial begin
        o_obj_req = 1'b0;
        o_obj_wr = 1'b0;
        o_obj_index = 16'h0000;
        o_obj_wdata = 32'h00000000;
    end

    // launched on a falling edge, taken on the next rising edge
    task automatic access(input logic wr, input logic [15:0] idx,
                          input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic err,
                          output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        rdata = 32'h00000000;
        err = 1'b0;
        @(negedge i_core_clk);
        o_obj_req = 1'b1;
        o_obj_wr = wr;
        o_obj_index = idx;
        o_obj_wdata = wdata;
        @(negedge i_core_clk);
        o_obj_req = 1'b0;
        // released fields scrambled so stale values cannot pass
        o_obj_wr = ~wr;
        o_obj_index = ~idx;
        o_obj_wdata = ~wdata;
        while (!ok && n < 3) begin
            if (i_obj_ack === 1'b1) begin
                ok = 1'b1;
                rdata = i_obj_rdata;
                err = i_obj_err;
            end else begin
                n++;
                @(negedge i_core_clk);
            end
        end
    endtask
endmodule

`default_nettype wire

// ===== bench/test_position_velocity_monitor.sv
/*
 test_position_velocity_monitor: object access and supervision tests.
 Assumes a fixed 50000-cycle ms tick, so only timeouts of zero fit.
*/
`timescale 1ns/100ps
`default_nettype none

module test_position_velocity_monitor;
    import pvm_pkg::*;
    logic clk, rst, homing, react, req, wr, ack, err, raw_ok;
    logic [15:0] idx, stat;
    logic [31:0] wdata, rdata;
    motion_in_t mot;
    monitor_out_t mon;
    int error_cnt = 0, comparisons = 0, cyc = 0, hist = 0, lag_ev = 0;
    logic signed [7:0] modes [13] = '{MODE_AUTO_SETUP, MODE_CLOCK_DIR,
        MODE_NONE, MODE_PROFILE_POS, MODE_VELOCITY, MODE_PROFILE_VEL,
        MODE_PROFILE_TRQ, 8'sh05, MODE_HOMING, MODE_INTERP_POS, MODE_CSP,
        MODE_CSV, MODE_CST};

    position_velocity_monitor position_velocity_monitor_i (
        .i_core_clk(clk), .i_rst(rst), .i_motion(mot),
        .i_homing_done(homing), .i_lag_reaction_en(react),
        .i_obj_req(req), .i_obj_wr(wr), .i_obj_index(idx),
        .i_obj_wdata(wdata), .o_obj_ack(ack), .o_obj_err(err),
        .o_obj_rdata(rdata), .o_raw_valid(raw_ok), .o_status_bits(stat),
        .o_mon(mon));
    object_master object_master_i (
        .i_core_clk(clk), .i_obj_ack(ack), .i_obj_err(err),
        .i_obj_rdata(rdata), .o_obj_req(req), .o_obj_wr(wr),
        .o_obj_index(idx), .o_obj_wdata(wdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // tick phase is fixed, so the long waits set the ceiling
    always @(posedge clk) begin
        cyc++;
        if (mon.history_entry === 1'b1) hist++;
        if (mon.lag_event === 1'b1) lag_ev++;
        if (cyc == 105000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [15:0] i,
                        input logic [31:0] d, input logic [31:0] exp,
                        input logic exp_err);
        logic [31:0] rd;
        logic e, ok;
        object_master_i.access(w, i, d, rd, e, ok);
        check({31'h0, ok}, 32'h1);
        check({31'h0, e}, {31'h0, exp_err});
        if (!w && !exp_err) check(rd, exp);
    endtask

    task automatic final_report();
        $display("mismatches=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        mot = '0;
        homing = 1'b0;
        react = 1'b1;
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        xfer(0, IDX_MODE_SHOWN, 0, 32'h0, 0);
        xfer(0, IDX_DEMAND_POS, 0, 32'h0, 0);
        xfer(0, IDX_ACTUAL_POS, 0, 32'h0, 0);
        xfer(0, IDX_SPEED_SETPT, 0, 32'h0, 0);
        xfer(0, IDX_LAG_LIMIT, 0, 32'h00000100, 0);
        xfer(0, IDX_LAG_TIMEOUT, 0, 32'h00000064, 0);
        xfer(0, IDX_ARR_WINDOW, 0, 32'h0000000A, 0);
        xfer(0, IDX_ARR_TIME, 0, 32'h00000064, 0);
        check({31'h0, raw_ok}, 32'h0);
        xfer(0, 16'h6069, 0, 0, 1);
        xfer(1, IDX_ACTUAL_POS, 32'h5, 0, 1);
        xfer(1, IDX_MODE_SHOWN, 32'h1, 0, 1);
        xfer(0, IDX_ACTUAL_POS, 0, 32'h0, 0);
        xfer(1, IDX_LAG_LIMIT, 32'h12345678, 0, 0);
        xfer(0, IDX_LAG_LIMIT, 0, 32'h12345678, 0);
        xfer(1, IDX_ARR_TIME, 32'hFFFFABCD, 0, 0);
        xfer(0, IDX_ARR_TIME, 0, 32'h0000ABCD, 0);
        foreach (modes[k]) begin
            mot.mode = modes[k];
            xfer(0, IDX_MODE_SHOWN, 0, {{24{modes[k][7]}}, modes[k]}, 0);
        end
        mot.demand_pos = 32'sh80000001;
        mot.actual_pos = 32'sh7FFFFFFE;
        mot.raw_enc_pos = 32'sh00C0FFEE;
        mot.speed_setpt = 32'shFFFFFF9C;
        mot.speed_actual = 32'sh00000321;
        mot.enc_resolution = 32'h00000005;
        xfer(0, IDX_DEMAND_POS, 0, 32'h80000001, 0);
        xfer(0, IDX_ACTUAL_POS, 0, 32'h7FFFFFFE, 0);
        xfer(0, IDX_SPEED_SETPT, 0, 32'hFFFFFF9C, 0);
        xfer(0, IDX_SPEED_ACTUAL, 0, 32'h00000321, 0);
        check({31'h0, raw_ok}, 32'h1);
        homing = 1'b1;
        @(negedge clk);
        homing = 1'b0;
        xfer(0, IDX_RAW_ENC_POS, 0, 32'h00C0FFEE, 0);
        // zero timeouts: one tick of persistence is all the run can afford
        xfer(1, IDX_LAG_LIMIT, 32'h00000100, 0, 0);
        xfer(1, IDX_LAG_TIMEOUT, 32'h0, 0, 0);
        xfer(1, IDX_ARR_TIME, 32'h0, 0, 0);
        mot.mode = MODE_PROFILE_POS;
        mot.actual_pos = 32'sd1000;
        mot.demand_pos = 32'sd1256;
        mot.target_pos = 32'sd1010;
        while (cyc < 52000) @(negedge clk);
        check({16'h0, stat}, 32'h0);
        check(hist, 0);
        check(lag_ev, 0);
        mot.demand_pos = 32'sd1257;
        mot.target_pos = 32'sd991;
        // both conditions true now, but no tick yet: nothing may flag
        repeat (10) @(negedge clk);
        check({16'h0, stat}, 32'h0);
        while (stat[STAT_LAG_BIT] !== 1'b1 && cyc < 104000) @(negedge clk);
        repeat (5) @(negedge clk);
        check({16'h0, stat}, 32'h00002400);
        check({28'h0, mon[3:2]}, 32'h3);
        check(hist, 1);
        check(lag_ev, 1);
        xfer(1, IDX_LAG_LIMIT, MON_OFF, 0, 0);
        repeat (5) @(negedge clk);
        check({16'h0, stat}, 32'h00000400);
        xfer(1, IDX_ARR_WINDOW, MON_OFF, 0, 0);
        repeat (5) @(negedge clk);
        check({16'h0, stat}, 32'h0);
        final_report();
    end
endmodule

`default_nettype wire
